// ===== hdl/addr_decode_params.svh
// Address decoder constants: region bounds, memory bounds and master count.
// Assumes inclusion by bare name from the decoder modules.
`ifndef ADDR_DECODE_PARAMS_SVH
`define ADDR_DECODE_PARAMS_SVH

// Top-level regions, inclusive bounds
`define PROG_LO 32'h0000_0000
`define PROG_HI 32'h1FFF_FFFF
`define NOMEM_LO 32'h2000_0000
`define NOMEM_HI 32'h3FFF_FFFF
`define PERI_LO 32'h4000_0000
`define PERI_HI 32'h5FFF_FFFF
`define SERMEM_LO 32'h6000_0000
`define SERMEM_HI 32'h9FFF_FFFF
`define UNUSED_LO 32'hA000_0000
`define UNUSED_HI 32'hDFFF_FFFF
`define PRIV_LO 32'hE000_0000
`define PRIV_HI 32'hE00F_FFFF
`define SYSREG_LO 32'hE010_A000
`define SYSREG_HI 32'hFFFF_FFFF

// Memories inside the program region
`define ROM_LO 32'h0000_0000
`define ROM_HI 32'h0000_FFFF
`define SRAM_LO 32'h0800_0000
`define SRAM_HI 32'h0801_FFFF
`define AFLASH_LO 32'h1000_0000
`define AFLASH_HI 32'h1003_FFFF
`define SUPERVISORY_FLASH_LO 32'h1600_0000
`define SUPERVISORY_FLASH_HI 32'h1600_7FFF

// Number of requesting masters
`define NUM_MASTERS 2

`endif

// ===== hdl/addr_decode_pkg.sv
// Address decoder types: target codes, request and answer structs.
// Assumes nothing beyond a SystemVerilog compiler.
package addr_decode_pkg;

  // One-hot target select
  typedef enum logic [8:0] {
    TGT_NONE = 9'h001,
    TGT_ROM = 9'h002,
    TGT_SRAM = 9'h004,
    TGT_AFLASH = 9'h008,
    TGT_SUPERVISORY_FLASH = 9'h010,
    TGT_PERI = 9'h020,
    TGT_SERMEM = 9'h040,
    TGT_PRIV = 9'h080,
    TGT_SYSREG = 9'h100
  } target_t;

  // Request from a master
  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    logic [31:0] addr;
  } req_t;

  // Registered routing result
  typedef struct packed {
    logic valid;
    target_t target;
    logic [31:0] addr;
    logic write;
    logic wr_block;
    logic error;
  } route_t;

  // Arbiter state
  typedef enum logic [1:0] {
    GRANT_MAIN = 2'h1,
    GRANT_SEC = 2'h2
  } grant_t;

endpackage

// ===== hdl/region_lookup.sv
// Combinational region lookup of one 32-bit address.
// Assumes the address and attributes are stable within the cycle.
`timescale 1ns/100ps
`default_nettype none
`include "addr_decode_params.svh"

module region_lookup (
  // Request
  input wire addr_decode_pkg::req_t req,
  input wire logic secure_stage,
  // Result
  output var addr_decode_pkg::target_t target,
  output logic wr_block,
  output logic error
);

  // Inclusive range test
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Map address to target, master-independent
  always_comb begin
    target = addr_decode_pkg::TGT_NONE; // RULE_01
    wr_block = 1'b0;
    if (in_range(req.addr, `ROM_LO, `ROM_HI)) begin
      target = addr_decode_pkg::TGT_ROM; // RULE_09
    end else if (in_range(req.addr, `SRAM_LO, `SRAM_HI)) begin
      target = addr_decode_pkg::TGT_SRAM; // RULE_10
    end else if (in_range(req.addr, `AFLASH_LO, `AFLASH_HI)) begin
      target = addr_decode_pkg::TGT_AFLASH; // RULE_11
    end else if (in_range(req.addr, `SUPERVISORY_FLASH_LO, `SUPERVISORY_FLASH_HI)) begin
      target = addr_decode_pkg::TGT_SUPERVISORY_FLASH; // RULE_12
      wr_block = req.write && secure_stage; // RULE_14
    end else if (in_range(req.addr, `PROG_LO, `PROG_HI)) begin
      target = addr_decode_pkg::TGT_NONE; // RULE_02
    end else if (in_range(req.addr, `NOMEM_LO, `NOMEM_HI)) begin
      target = addr_decode_pkg::TGT_NONE; // RULE_03
    end else if (in_range(req.addr, `PERI_LO, `PERI_HI)) begin
      target = req.fetch ? addr_decode_pkg::TGT_NONE : addr_decode_pkg::TGT_PERI; // RULE_04
    end else if (in_range(req.addr, `SERMEM_LO, `SERMEM_HI)) begin
      target = addr_decode_pkg::TGT_SERMEM; // RULE_05
    end else if (in_range(req.addr, `UNUSED_LO, `UNUSED_HI)) begin
      target = addr_decode_pkg::TGT_NONE; // RULE_06
    end else if (in_range(req.addr, `PRIV_LO, `PRIV_HI)) begin
      target = addr_decode_pkg::TGT_PRIV; // RULE_07
    end else if (in_range(req.addr, `SYSREG_LO, `SYSREG_HI)) begin
      target = addr_decode_pkg::TGT_SYSREG; // RULE_08
    end
    // Unmapped or refused gives an error
    error = req.valid && (target == addr_decode_pkg::TGT_NONE); // RULE_15
  end

endmodule
`default_nettype wire

// ===== hdl/system_address_decoder.sv
// System address decoder: two masters share one fixed 32-bit map.
// Assumes masters hold requests until granted; one clock, async reset.
// Overview of operation
// RULE_01: Fixed 32-bit map, same for every master
// RULE_02: Low 512 MB is the program region
// RULE_03: 0x2000_0000 window has no memory
// RULE_04: Peripheral space; fetches refused, no bit-band
// RULE_05: Serial memory window allows fetch and data
// RULE_06: 0xA000_0000 to 0xDFFF_FFFF unused
// RULE_07: Core-private bus window
// RULE_08: Device system register region
// RULE_09: 64 KB boot ROM at zero
// RULE_10: 128 KB SRAM at 0x0800_0000
// RULE_11: 256 KB application flash at 0x1000_0000
// RULE_12: 32 KB supervisory flash at 0x1600_0000
// RULE_13: Both cores share one identical map
// RULE_14: Secure stage blocks supervisory flash writes
// RULE_15: Unmapped access answers with bus error
`timescale 1ns/100ps
`default_nettype none
`include "addr_decode_params.svh"

module system_address_decoder (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Lifecycle
  input wire logic SECURE_STAGE,
  // Main core request
  input wire addr_decode_pkg::req_t MAIN_REQ,
  output logic MAIN_GNT,
  // Secondary core request
  input wire addr_decode_pkg::req_t SEC_REQ,
  output logic SEC_GNT,
  // Routed access
  output var addr_decode_pkg::route_t ROUTE,
  output logic [1:0] ROUTE_MASTER
);

  // Whole state of the block
  typedef struct packed {
    addr_decode_pkg::grant_t last;
    addr_decode_pkg::route_t route;
    logic [1:0] master;
  } state_t;

  state_t s_q; // Registered state
  state_t s_d; // Next state
  addr_decode_pkg::req_t sel_req; // Chosen request
  addr_decode_pkg::target_t tgt; // Lookup target
  logic blk; // Write blocked
  logic err; // Error flag
  logic pick_sec; // Secondary wins this cycle

  // Shared lookup for both cores
  region_lookup u_lookup ( // RULE_13
    .req(sel_req),
    .secure_stage(SECURE_STAGE),
    .target(tgt),
    .wr_block(blk),
    .error(err)
  );

  // Round-robin pick and next state
  always_comb begin
    s_d = s_q;
    pick_sec = SEC_REQ.valid && (!MAIN_REQ.valid || s_q.last == addr_decode_pkg::GRANT_MAIN);
    sel_req = pick_sec ? SEC_REQ : MAIN_REQ; // RULE_13
    s_d.route.valid = sel_req.valid;
    s_d.route.target = tgt;
    s_d.route.addr = sel_req.addr;
    // Write qualified by valid, so released request lines never show a write
    s_d.route.write = sel_req.valid && sel_req.write && !blk; // RULE_14
    s_d.route.wr_block = sel_req.valid && blk;
    s_d.route.error = err; // RULE_15
    if (sel_req.valid) begin
      s_d.last = pick_sec ? addr_decode_pkg::GRANT_SEC : addr_decode_pkg::GRANT_MAIN;
      s_d.master = pick_sec ? 2'h2 : 2'h1;
    end else begin
      s_d.master = 2'h0;
    end
  end

  // State register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s_q <= '{last: addr_decode_pkg::GRANT_SEC, route: '{valid: 1'b0,
               target: addr_decode_pkg::TGT_NONE, addr: 32'h0000_0000,
               write: 1'b0, wr_block: 1'b0, error: 1'b0}, master: 2'h0};
    end else begin
      s_q <= s_d;
    end
  end

  // Grants are combinational
  assign MAIN_GNT = MAIN_REQ.valid && !pick_sec;
  assign SEC_GNT = pick_sec;
  assign ROUTE = s_q.route;
  assign ROUTE_MASTER = s_q.master;

  // Checks
  rom_sel_a: assert property (@(posedge CLK) disable iff (!NRST) // RULE_09
    sel_req.valid && sel_req.addr <= `ROM_HI |=> ROUTE.target == addr_decode_pkg::TGT_ROM)
    else $error("boot rom not selected");
  nomem_err_a: assert property (@(posedge CLK) disable iff (!NRST) // RULE_03
    sel_req.valid && sel_req.addr[31:29] == 3'h1 |=> ROUTE.error)
    else $error("no-memory window not errored");
  peri_fetch_a: assert property (@(posedge CLK) disable iff (!NRST) // RULE_04
    sel_req.valid && sel_req.fetch && sel_req.addr[31:29] == 3'h2 |=> ROUTE.error)
    else $error("peripheral fetch not refused");
  sermem_ok_a: assert property (@(posedge CLK) disable iff (!NRST) // RULE_05
    sel_req.valid && sel_req.addr >= `SERMEM_LO && sel_req.addr <= `SERMEM_HI
    |=> ROUTE.target == addr_decode_pkg::TGT_SERMEM && !ROUTE.error)
    else $error("serial memory window misrouted");
  unused_err_a: assert property (@(posedge CLK) disable iff (!NRST) // RULE_06
    sel_req.valid && sel_req.addr >= `UNUSED_LO && sel_req.addr <= `UNUSED_HI |=> ROUTE.error)
    else $error("unused window not errored");
  priv_sel_a: assert property (@(posedge CLK) disable iff (!NRST) // RULE_07
    sel_req.valid && sel_req.addr[31:20] == 12'hE00 |=> ROUTE.target == addr_decode_pkg::TGT_PRIV)
    else $error("private bus not selected");
  supervisory_flash_lock_a: assert property (@(posedge CLK) disable iff (!NRST) // RULE_14
    sel_req.valid && sel_req.write && SECURE_STAGE && sel_req.addr >= `SUPERVISORY_FLASH_LO &&
    sel_req.addr <= `SUPERVISORY_FLASH_HI |=> !ROUTE.write && ROUTE.wr_block)
    else $error("secure flash write passed");
  err_none_a: assert property (@(posedge CLK) disable iff (!NRST) // RULE_15
    ROUTE.error |-> ROUTE.valid && ROUTE.target == addr_decode_pkg::TGT_NONE)
    else $error("error without unmapped target");
  fair_grant_a: assert property (@(posedge CLK) disable iff (!NRST) // RULE_13
    MAIN_REQ.valid && SEC_REQ.valid && MAIN_GNT |=> !(MAIN_REQ.valid && SEC_REQ.valid) || SEC_GNT)
    else $error("secondary core starved");

  sram_cov_c: cover property (@(posedge CLK) ROUTE.valid && ROUTE.target == addr_decode_pkg::TGT_SRAM);
  both_req_c: cover property (@(posedge CLK) MAIN_REQ.valid && SEC_REQ.valid);
  err_cov_c: cover property (@(posedge CLK) ROUTE.error);
  lock_cov_c: cover property (@(posedge CLK) ROUTE.wr_block);

endmodule
`default_nettype wire

// ===== tb/core_model.sv
// Bus master model: one processor core issuing requests to the decoder.
// Assumes the bench pulses go for one cycle with a command on cmd.
`timescale 1ns/100ps
`default_nettype none

module core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Command from the bench
  input wire logic go,
  input wire logic [33:0] cmd,
  // Decoder side
  input wire logic gnt,
  output var addr_decode_pkg::req_t req
);
  // Raise on go, hold until taken, then release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req <= '0;
    end else if (req.valid && gnt) begin
      // Released lines show the inverse, not the old value
      req <= {1'b0, ~req.write, ~req.fetch, ~req.addr};
    end else if (go) begin
      req <= {1'b1, cmd};
    end
  end
endmodule

`default_nettype wire

// ===== tb/system_address_decoder_test.sv
// Testbench for the system address decoder with two core models.
// Assumes a 100 ns clock and the one-hot target codes of the package.
`timescale 1ns/100ps
`default_nettype none

module system_address_decoder_test;
  // Clock, reset and bench commands
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic SECURE_STAGE = 1'b0;
  logic go_m = 1'b0;
  logic go_s = 1'b0;
  logic [33:0] cmd_m = '0;
  logic [33:0] cmd_s = '0;
  // Design side wires
  addr_decode_pkg::req_t main_req, sec_req;
  logic main_gnt, sec_gnt;
  addr_decode_pkg::route_t ROUTE;
  logic [1:0] ROUTE_MASTER;
  int errors = 0;
  int check_count = 0;
  // Probe addresses with expected one-hot target
  logic [40:0] map [16] = '{
    {9'h002, 32'h0000_0000}, {9'h002, 32'h0000_FFFF}, {9'h001, 32'h0001_0000},
    {9'h004, 32'h0800_0000}, {9'h004, 32'h0801_FFFF}, {9'h008, 32'h1003_FFFF},
    {9'h010, 32'h1600_7FFF}, {9'h001, 32'h1600_8000}, {9'h001, 32'h2000_0000},
    {9'h020, 32'h5FFF_FFFF}, {9'h040, 32'h6000_0000}, {9'h001, 32'hA000_0000},
    {9'h080, 32'hE00F_FFFF}, {9'h001, 32'hE010_9FFF}, {9'h100, 32'hE010_A000},
    {9'h100, 32'hFFFF_FFFF}};

  // Design and the two masters
  system_address_decoder u_system_address_decoder (.CLK(CLK), .NRST(NRST),
    .SECURE_STAGE(SECURE_STAGE), .MAIN_REQ(main_req), .MAIN_GNT(main_gnt),
    .SEC_REQ(sec_req), .SEC_GNT(sec_gnt), .ROUTE(ROUTE), .ROUTE_MASTER(ROUTE_MASTER));
  core_model u_core_model (.clk(CLK), .nrst(NRST), .go(go_m), .cmd(cmd_m),
    .gnt(main_gnt), .req(main_req));
  core_model u_core_model_sec (.clk(CLK), .nrst(NRST), .go(go_s), .cmd(cmd_s),
    .gnt(sec_gnt), .req(sec_req));

  // Clock generator
  initial begin
    forever #50 CLK = ~CLK;
  end

  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One access through a master, waiting for its route
  task automatic acc(input logic [1:0] m, input logic [1:0] wf, input logic [31:0] a);
    int n;
    n = 0;
    @(posedge CLK);
    if (m == 2'h1) begin
      cmd_m <= {wf, a};
      go_m <= 1'b1;
    end else begin
      cmd_s <= {wf, a};
      go_s <= 1'b1;
    end
    @(posedge CLK);
    go_m <= 1'b0;
    go_s <= 1'b0;
    do begin
      @(negedge CLK);
      n++;
    end while (!(ROUTE.valid === 1'b1 && ROUTE_MASTER === m) && n < 20);
    chk("valid", 32'h1, ROUTE.valid);
    chk("master", {30'h0, m}, {30'h0, ROUTE_MASTER});
    chk("addr", a, ROUTE.addr);
  endtask

  // Whole map from both masters
  task automatic t_map;
    for (int m = 1; m < 3; m++) begin
      for (int i = 0; i < 16; i++) begin
        acc(m[1:0], 2'b00, map[i][31:0]);
        chk("target", map[i][40:32], ROUTE.target);
        chk("error", map[i][40:32] == 9'h001, ROUTE.error);
      end
    end
    $display("map test done");
  endtask

  // Fetch refused in peripheral space, allowed in serial memory
  task automatic t_fetch;
    acc(2'h1, 2'b01, 32'h4000_0000);
    chk("target", 32'h001, ROUTE.target);
    chk("error", 32'h1, ROUTE.error);
    acc(2'h1, 2'b01, 32'h9FFF_FFFF);
    chk("target", 32'h040, ROUTE.target);
    chk("error", 32'h0, ROUTE.error);
    $display("fetch test done");
  endtask

  // Supervisory flash writes with and without secure stage
  task automatic t_secure;
    @(posedge CLK);
    SECURE_STAGE <= 1'b1;
    acc(2'h2, 2'b10, 32'h1600_0000);
    chk("write", 32'h0, ROUTE.write);
    chk("wr_block", 32'h1, ROUTE.wr_block);
    @(posedge CLK);
    SECURE_STAGE <= 1'b0;
    acc(2'h2, 2'b10, 32'h1600_0000);
    chk("write", 32'h1, ROUTE.write);
    chk("wr_block", 32'h0, ROUTE.wr_block);
    $display("secure test done");
  endtask

  // Both masters at once, each routed once
  task automatic t_both;
    int seen;
    seen = 0;
    @(posedge CLK);
    cmd_m <= {2'b00, 32'h1000_0000};
    cmd_s <= {2'b00, 32'h0800_0000};
    go_m <= 1'b1;
    go_s <= 1'b1;
    @(posedge CLK);
    go_m <= 1'b0;
    go_s <= 1'b0;
    repeat (6) begin
      @(negedge CLK);
      if (ROUTE.valid === 1'b1) seen = seen + ROUTE_MASTER;
    end
    chk("masters", 32'd3, seen);
    $display("both test done");
  endtask

  // Verdict and end of run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge CLK);
    NRST <= 1'b1;
    t_map;
    t_fetch;
    t_secure;
    t_both;
    end_of_test;
  end

  // Watchdog against a hang
  initial begin
    #2000000;
    errors++;
    end_of_test;
  end
endmodule

`default_nettype wire
